/* File: common/isr_pkg.sv */
// shared constants for the instrument status reporting block
package isr_pkg;
  // standard event bit positions
  localparam int EV_OPC_BIT = 0;
  localparam int EV_QYE_BIT = 2;
  localparam int EV_DEV_BIT = 3;
  localparam int EV_EXE_BIT = 4;
  localparam int EV_CME_BIT = 5;
  localparam int EV_PON_BIT = 7;
  localparam logic [7:0] EV_USED_MASK = 8'hBD;
  localparam logic [7:0] EV_ERR_MASK = 8'h3C;
  // summary status byte bit positions
  localparam int SB_DOUBT_BIT = 3;
  localparam int SB_MAV_BIT = 4;
  localparam int SB_ESB_BIT = 5;
  localparam int SB_RQS_BIT = 6;
  localparam logic [7:0] SB_SRE_USED = 8'h38;
  // questionable event bit positions
  localparam int QU_VOLT_BIT = 0;
  localparam int QU_CURR_BIT = 1;
  localparam int QU_TEMP_BIT = 4;
  localparam int QU_OVP_BIT = 9;
  localparam int QU_OCP_BIT = 10;
  localparam logic [15:0] QU_USED_MASK = 16'h0613;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [4:0] RST_CODE = 5'h00;
  // fixed latency of the power-on capture after reset release
  localparam int PON_CAPTURE_CYCLES = 1;
endpackage : isr_pkg

/* File: verilog/isr_event_latch.sv */
// generic sticky event register with set-over-clear priority
`timescale 1ns/1ps
module isr_event_latch #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] USED = '1
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] flags_o
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } isr_latch_t;
  isr_latch_t state_q;
  isr_latch_t state_d;

  always_comb begin
    state_d = state_q;
    // set wins over the clearing read in the same cycle
    state_d.flags = ((clear_i ? '0 : state_q.flags) | set_i) & USED; // [RQ19] [RQ23]
  end

  // reset deliberately leaves flags alone: event bits survive a reset
  always_ff @(posedge clock_i) begin
    state_q <= state_d; // [RQ19]
  end

  assign flags_o = state_q.flags;

  latch_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !clear_i |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
    else $error("event bit dropped without a clear"); // [RQ19]
endmodule : isr_event_latch

/* File: verilog/isr_error_queue.sv */
// error queue occupancy tracker; contents live elsewhere
`timescale 1ns/1ps
module isr_error_queue #(
  parameter int DEPTH = 20
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic clear_i,
  output logic [4:0] count_o,
  output logic overflow_o
);
  typedef struct packed {
    logic [4:0] count;
    logic overflow;
  } isr_queue_t;
  isr_queue_t state_q;
  isr_queue_t state_d;

  always_comb begin
    state_d = state_q;
    if (clear_i) begin
      state_d.count = isr_pkg::RST_CODE;
      state_d.overflow = 1'b0;
    end else begin
      if (push_i && !pop_i) begin
        if (state_q.count == 5'(DEPTH)) begin
          // newest slot becomes the too-many-errors marker
          state_d.overflow = 1'b1;
        end else begin
          state_d.count = state_q.count + 5'h01;
        end
      end else if (pop_i && !push_i && state_q.count != 5'h00) begin
        state_d.count = state_q.count - 5'h01;
        state_d.overflow = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count_o = state_q.count;
  assign overflow_o = state_q.overflow;
endmodule : isr_error_queue

/* File: verilog/isr_status_core.sv */
// status reporting core: standard event, questionable, summary byte, service request
`timescale 1ns/1ps
// Summary of operation
// [RQ1] operation complete pulse sets standard event bit 0
// [RQ2] query error pulse sets bit 2
// [RQ3] self-test or calibration fault pulse sets bit 3
// [RQ4] execution error pulse sets bit 4
// [RQ5] syntax error sets bit 5; bits 1 and 6 read zero
// [RQ6] power-on seen sets bit 7 until read or cleared
// [RQ7] setting any of bits 2 to 5 pushes an error queue entry
// [RQ8] summary bit 5 is OR of enabled standard event bits
// [RQ9] written enable value is stored as the mask
// [RQ10] clear status or event query clears the standard event register
// [RQ11] event mask cleared by zero write, at power-on only if clear setting is 1
// [RQ12] message available follows output buffer data, clears once all read
// [RQ13] summary bits are live, follow their event registers
// [RQ14] bit 3 reflects enabled questionable bits; bits 0-2 and 7 zero
// [RQ15] bit 6 shows a service request, read by serial poll
// [RQ16] clear status clears summary; event query clears only bit 5
// [RQ17] questionable mask cleared by writing zero
// [RQ18] request mask cleared by zero write, at power-on only if setting is 1
// [RQ19] event bits latch until read or clear status; reset keeps them
// [RQ20] questionable bits 0,1,4,9,10 map regulation, fan, trip conditions
// [RQ21] enabled summary bit sets service request and asserts bus request
// [RQ22] serial poll returns the byte and clears only service request
// [RQ23] set pulse wins over a clearing read in the same cycle
module isr_status_core #(
  parameter int QDEPTH = 20
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic power_up_i,
  input wire logic op_complete_i,
  input wire logic query_error_i,
  input wire logic device_fault_i,
  input wire logic bad_param_i,
  input wire logic command_error_i,
  input wire logic volt_unreg_i,
  input wire logic curr_unreg_i,
  input wire logic fan_overtemp_i,
  input wire logic ovp_trip_i,
  input wire logic ocp_trip_i,
  input wire logic out_buf_nonempty_i,
  input wire logic clear_status_i,
  input wire logic event_query_i,
  input wire logic doubtful_summary_query_i,
  input wire logic poll_i,
  input wire logic error_pop_i,
  input wire logic ese_write_i,
  input wire logic sre_write_i,
  input wire logic doubtful_summary_en_write_i,
  input wire logic psc_write_i,
  input wire logic [15:0] write_data_i,
  output logic [7:0] event_flags_o,
  output logic [7:0] event_mask_o,
  output logic [15:0] doubtful_summary_flags_o,
  output logic [15:0] doubtful_summary_mask_o,
  output logic [7:0] status_byte_o,
  output logic [7:0] request_mask_o,
  output logic power_on_clear_o,
  output logic service_request_o,
  output logic [7:0] poll_data_o,
  output logic [4:0] error_count_o
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0] ev_mask;
    logic [15:0] qu_mask;
    logic [7:0] sr_mask;
    logic psc;
    logic pon_pend;
    logic service_request;
    logic [7:0] stb;
    logic [7:0] poll;
    logic [7:0] ev_out;
    logic [15:0] qu_out;
    logic srq;
    logic err_push;
    logic cause;
  } isr_core_t;
  isr_core_t state_q;
  isr_core_t state_d;

  logic [7:0] ev_flags;
  logic [15:0] qu_flags;
  logic [7:0] ev_set;
  logic [15:0] qu_set;
  logic [4:0] err_count;
  logic err_ovf;
  logic ev_clear;
  logic qu_clear;
  logic doubt_sum;
  logic esb_sum;
  logic [7:0] live_sb;

  function automatic logic any_enabled(input logic [15:0] flags, input logic [15:0] mask);
    any_enabled = |(flags & mask);
  endfunction : any_enabled

  // ************************************************
  // event sources
  // ************************************************
  always_comb begin
    ev_set = 8'h00;
    ev_set[isr_pkg::EV_OPC_BIT] = op_complete_i; // [RQ1]
    ev_set[isr_pkg::EV_QYE_BIT] = query_error_i; // [RQ2]
    ev_set[isr_pkg::EV_DEV_BIT] = device_fault_i; // [RQ3]
    ev_set[isr_pkg::EV_EXE_BIT] = bad_param_i; // [RQ4]
    ev_set[isr_pkg::EV_CME_BIT] = command_error_i; // [RQ5]
    ev_set[isr_pkg::EV_PON_BIT] = state_q.pon_pend; // [RQ6]
    qu_set = 16'h0000;
    qu_set[isr_pkg::QU_VOLT_BIT] = volt_unreg_i; // [RQ20]
    qu_set[isr_pkg::QU_CURR_BIT] = curr_unreg_i; // [RQ20]
    qu_set[isr_pkg::QU_TEMP_BIT] = fan_overtemp_i; // [RQ20]
    qu_set[isr_pkg::QU_OVP_BIT] = ovp_trip_i; // [RQ20]
    qu_set[isr_pkg::QU_OCP_BIT] = ocp_trip_i; // [RQ20]
  end

  assign ev_clear = clear_status_i | event_query_i; // [RQ10]
  assign qu_clear = clear_status_i | doubtful_summary_query_i;

  isr_event_latch #(
    .WIDTH(8),
    .USED(isr_pkg::EV_USED_MASK)
  ) u_std_event (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .set_i(ev_set),
    .clear_i(ev_clear),
    .flags_o(ev_flags)
  );

  isr_event_latch #(
    .WIDTH(16),
    .USED(isr_pkg::QU_USED_MASK)
  ) u_doubtful_summary_event (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .set_i(qu_set),
    .clear_i(qu_clear),
    .flags_o(qu_flags)
  );

  // queue clears with clear status; one push per error pulse cycle
  isr_error_queue #(
    .DEPTH(QDEPTH)
  ) u_err_queue (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .push_i(|(ev_set & isr_pkg::EV_ERR_MASK)), // [RQ7]
    .pop_i(error_pop_i),
    .clear_i(clear_status_i),
    .count_o(err_count),
    .overflow_o(err_ovf)
  );

  // ************************************************
  // live summary; nothing here latches so clears show at once
  // ************************************************
  assign doubt_sum = any_enabled(qu_flags, state_q.qu_mask); // [RQ14]
  assign esb_sum = any_enabled({8'h00, ev_flags}, {8'h00, state_q.ev_mask}); // [RQ8] [RQ13]

  always_comb begin
    live_sb = 8'h00;
    live_sb[isr_pkg::SB_DOUBT_BIT] = doubt_sum && !qu_clear; // [RQ13] [RQ14]
    live_sb[isr_pkg::SB_MAV_BIT] = out_buf_nonempty_i; // [RQ12]
    live_sb[isr_pkg::SB_ESB_BIT] = esb_sum && !ev_clear; // [RQ16]
  end

  // ************************************************
  // control state
  // ************************************************
  always_comb begin
    state_d = state_q;
    state_d.err_push = |(ev_set & isr_pkg::EV_ERR_MASK);
    state_d.pon_pend = 1'b0;
    if (ese_write_i) begin
      state_d.ev_mask = write_data_i[7:0]; // [RQ9] [RQ11]
    end
    if (doubtful_summary_en_write_i) begin
      state_d.qu_mask = write_data_i & isr_pkg::QU_USED_MASK; // [RQ17]
    end
    if (sre_write_i) begin
      state_d.sr_mask = write_data_i[7:0] & isr_pkg::SB_SRE_USED; // [RQ18]
    end
    if (psc_write_i) begin
      state_d.psc = write_data_i[0];
    end
    // request clears on poll, clear status, or when its cause goes away
    // only a fresh cause raises it, so a poll is not undone next cycle
    state_d.cause = |(live_sb & state_q.sr_mask);
    if (poll_i || !state_d.cause) begin
      state_d.service_request = 1'b0; // [RQ22]
    end else if (!state_q.cause) begin
      state_d.service_request = 1'b1; // [RQ21]
    end
    if (clear_status_i) begin
      state_d.service_request = 1'b0; // [RQ16]
    end
    state_d.stb = live_sb;
    state_d.stb[isr_pkg::SB_RQS_BIT] = state_d.service_request; // [RQ15]
    state_d.srq = state_d.service_request; // [RQ21]
    if (poll_i) begin
      state_d.poll = state_q.stb; // [RQ22]
    end
    state_d.ev_out = ev_flags;
    state_d.qu_out = qu_flags;
  end

  // power-up pulse marks power-on seen and applies the clear setting
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q.service_request <= 1'b0;
      state_q.stb <= isr_pkg::RST_BYTE;
      state_q.poll <= isr_pkg::RST_BYTE;
      state_q.ev_out <= isr_pkg::RST_BYTE;
      state_q.qu_out <= isr_pkg::RST_WORD;
      state_q.srq <= 1'b0;
      state_q.err_push <= 1'b0;
      state_q.pon_pend <= 1'b0;
      state_q.cause <= 1'b0;
    end else begin
      state_q.cause <= state_d.cause;
      state_q.service_request <= state_d.service_request;
      state_q.stb <= state_d.stb;
      state_q.poll <= state_d.poll;
      state_q.ev_out <= state_d.ev_out;
      state_q.qu_out <= state_d.qu_out;
      state_q.srq <= state_d.srq;
      state_q.err_push <= state_d.err_push;
      state_q.pon_pend <= power_up_i; // [RQ6]
    end
    // masks survive a plain reset; only power-up with the setting at 1 clears the event and request masks
    if (power_up_i && state_q.psc) begin
      state_q.ev_mask <= isr_pkg::RST_BYTE; // [RQ11]
      state_q.sr_mask <= isr_pkg::RST_BYTE; // [RQ18]
      state_q.qu_mask <= state_d.qu_mask;
      state_q.psc <= state_d.psc;
    end else begin
      state_q.ev_mask <= state_d.ev_mask;
      state_q.sr_mask <= state_d.sr_mask;
      state_q.qu_mask <= state_d.qu_mask;
      state_q.psc <= state_d.psc;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign event_flags_o = state_q.ev_out;
  assign event_mask_o = state_q.ev_mask;
  assign doubtful_summary_flags_o = state_q.qu_out;
  assign doubtful_summary_mask_o = state_q.qu_mask;
  assign status_byte_o = state_q.stb;
  assign request_mask_o = state_q.sr_mask;
  assign power_on_clear_o = state_q.psc;
  assign service_request_o = state_q.srq;
  assign poll_data_o = state_q.poll;
  assign error_count_o = err_count;

  // ************************************************
  // checks
  // ************************************************
  sequence err_pulse_s;
    query_error_i || device_fault_i || bad_param_i || command_error_i;
  endsequence

  opc_set_a: assert property (@(posedge clock_i) disable iff (reset_i)
    op_complete_i |=> ev_flags[0]) else $error("opc not set"); // [RQ1]
  err_push_a: assert property (@(posedge clock_i) disable iff (reset_i)
    err_pulse_s |=> state_q.err_push) else $error("no queue push"); // [RQ7]
  unused_ev_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !ev_flags[1] && !ev_flags[6]) else $error("unused event bit set"); // [RQ5]
  esb_live_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (esb_sum && !ev_clear) |=> status_byte_o[5]) else $error("esb missing"); // [RQ8]
  mav_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
    out_buf_nonempty_i |=> status_byte_o[4]) else $error("mav missing"); // [RQ12]
  clear_all_a: assert property (@(posedge clock_i) disable iff (reset_i)
    clear_status_i ##1 !op_complete_i[*1] |-> ev_flags == 8'h00 || $past(|ev_set))
    else $error("clear status left bits"); // [RQ10]
  stb_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
    status_byte_o[2:0] == 3'h0 && !status_byte_o[7]) else $error("unused sb bit"); // [RQ14]
  rqs_poll_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (poll_i && state_q.service_request) |=> !state_q.service_request) else $error("poll kept rqs"); // [RQ22]
  srq_pin_a: assert property (@(posedge clock_i) disable iff (reset_i)
    service_request_o == status_byte_o[6]) else $error("srq mismatch"); // [RQ21]
  ese_store_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (ese_write_i && !power_up_i) |=> event_mask_o == $past(write_data_i[7:0]))
    else $error("mask not stored"); // [RQ9]
endmodule : isr_status_core

/* File: testbench/isr_remote_host.sv */
// remote controller model that issues status commands to the block
`timescale 1ns/1ps
module isr_remote_host (
  input wire logic clock_i,
  output logic [8:0] cmd_o,
  output logic [15:0] data_o
);
  // ****
  // command strobes
  // ****
  initial begin
    cmd_o = '0;
    data_o = 16'h0000;
  end
  // one-cycle command; a mask is sent as the weighted sum of its bits
  task automatic send(input int kind, input logic [15:0] data);
    if (kind < 9) cmd_o[kind] <= 1'b1;
    data_o <= data;
    @(posedge clock_i);
    cmd_o <= '0;
    // released bus must not keep the last value
    data_o <= ~data;
  endtask : send
endmodule : isr_remote_host

/* File: testbench/instrument_status_reporting_tb.sv */
// self-checking testbench for the status reporting core
`timescale 1ns/1ps
module instrument_status_reporting_tb;
  // ****
  // signals and model state
  // ****
  logic clock_i, reset_i, power_up_i, mav_i, live, m_psc, m_polled, pco, srq;
  logic [4:0] ev_src, q_src, cnt_o;
  logic [8:0] cmd;
  logic [15:0] wdata, qf, qm, m_q, m_qen;
  logic [7:0] evf, evm, sb, rm, pd, m_ev, m_ese, m_sre;
  int n_fail, n_tests, cycles;

  isr_remote_host u_host (.clock_i(clock_i), .cmd_o(cmd), .data_o(wdata));

  isr_status_core u_dut (
    .clock_i(clock_i), .reset_i(reset_i), .power_up_i(power_up_i),
    .op_complete_i(ev_src[0]), .query_error_i(ev_src[1]), .device_fault_i(ev_src[2]),
    .bad_param_i(ev_src[3]), .command_error_i(ev_src[4]),
    .volt_unreg_i(q_src[0]), .curr_unreg_i(q_src[1]), .fan_overtemp_i(q_src[2]),
    .ovp_trip_i(q_src[3]), .ocp_trip_i(q_src[4]), .out_buf_nonempty_i(mav_i),
    .clear_status_i(cmd[0]), .event_query_i(cmd[1]), .doubtful_summary_query_i(cmd[2]),
    .poll_i(cmd[3]), .error_pop_i(cmd[4]), .ese_write_i(cmd[5]), .sre_write_i(cmd[6]),
    .doubtful_summary_en_write_i(cmd[7]), .psc_write_i(cmd[8]), .write_data_i(wdata),
    .event_flags_o(evf), .event_mask_o(evm), .doubtful_summary_flags_o(qf), .doubtful_summary_mask_o(qm),
    .status_byte_o(sb), .request_mask_o(rm), .power_on_clear_o(pco),
    .service_request_o(srq), .poll_data_o(pd), .error_count_o(cnt_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    // whole run needs under 5000 cycles
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ****
  // helpers
  // ****
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] map_ev(input logic [4:0] s);
    return {2'b00, s[4], s[3], s[2], s[1], 1'b0, s[0]};
  endfunction : map_ev

  function automatic logic [15:0] map_q(input logic [4:0] s);
    return {5'h00, s[4], s[3], 4'h0, s[2], 2'b00, s[1], s[0]};
  endfunction : map_q

  function automatic logic [7:0] stb_m();
    return {2'b00, |(m_ev & m_ese), mav_i, |(m_q & m_qen), 3'b000};
  endfunction : stb_m

  // one cycle of sources and one command, then settle and compare
  task automatic fire(input logic [4:0] es, input logic [4:0] qs, input logic power_on_seen,
                      input int kind, input logic [15:0] wd, input logic mv);
    logic [7:0] s0, pexp, pm;
    logic [4:0] c0;
    logic newerr;
    s0 = stb_m();
    c0 = cnt_o;
    newerr = |(map_ev(es) & isr_pkg::EV_ERR_MASK & ~m_ev);
    @(posedge clock_i);
    ev_src <= es;
    q_src <= qs;
    power_up_i <= power_on_seen;
    mav_i <= mv;
    u_host.send(kind, wd);
    ev_src <= 5'h00;
    q_src <= 5'h00;
    power_up_i <= 1'b0;
    if (kind == 3 && live) begin
      #1;
      pexp = s0 | {1'b0, |(s0 & m_sre), 6'h00};
      pm = m_polled ? 8'hBF : 8'hFF;
      chk("poll_data", {8'h00, pexp & pm}, {8'h00, pd & pm});
      chk("srq_after_poll", 16'h0000, {15'h0000, srq});
      m_polled = 1'b1;
    end
    if (kind == 0 || kind == 1) m_ev = 8'h00;
    if (kind == 0 || kind == 2) m_q = 16'h0000;
    m_ev = m_ev | map_ev(es) | {power_on_seen, 7'h00};
    m_q = m_q | map_q(qs);
    if (kind == 5) m_ese = wd[7:0];
    if (kind == 6) m_sre = wd[7:0] & isr_pkg::SB_SRE_USED;
    if (kind == 7) m_qen = wd & isr_pkg::QU_USED_MASK;
    if (kind == 8) m_psc = wd[0];
    if (power_on_seen && m_psc) begin
      m_ese = 8'h00;
      m_sre = 8'h00;
    end
    if ((stb_m() & m_sre) == 8'h00) m_polled = 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    if (live) begin
      chk("event_flags", {8'h00, m_ev}, {8'h00, evf});
      chk("event_mask", {8'h00, m_ese}, {8'h00, evm});
      chk("request_mask", {8'h00, m_sre}, {8'h00, rm});
      chk("doubtful_summary_flags", m_q, qf);
      chk("doubtful_summary_mask", m_qen, qm & isr_pkg::QU_USED_MASK);
      chk("power_on_clear", {15'h0000, m_psc}, {15'h0000, pco});
      chk("status_byte", {8'h00, stb_m()}, {8'h00, sb & 8'hBF});
      if (!m_polled) chk("service_request", {15'h0000, |(stb_m() & m_sre)}, {15'h0000, srq});
      if (!m_polled) chk("status_rqs", {15'h0000, |(stb_m() & m_sre)}, {15'h0000, sb[6]});
      if (kind != 0 && !power_on_seen && newerr) chk("error_push", 16'h0001, {15'h0000, (c0 == 5'd20) ? cnt_o == 5'd20 : cnt_o > c0});
      if (kind == 4 && !power_on_seen && !newerr) chk("error_pop", {11'h000, (c0 == 5'd0) ? c0 : c0 - 5'd1}, {11'h000, cnt_o});
    end
  endtask : fire

  task automatic do_reset();
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    m_polled = 1'b0;
    @(posedge clock_i);
    #1;
    chk("count_after_reset", 16'h0000, {11'h000, cnt_o});
  endtask : do_reset

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // ****
  // main sequence
  // ****
  initial begin
    int k;
    logic [4:0] e;
    reset_i = 1'b1;
    power_up_i = 1'b0;
    mav_i = 1'b0;
    ev_src = 5'h00;
    q_src = 5'h00;
    live = 1'b0;
    m_polled = 1'b0;
    void'($urandom(32'hB2E525A4));
    // event bits and masks survive reset: give them values while reset holds
    u_host.send(0, 16'h0000);
    u_host.send(8, 16'h0000);
    u_host.send(5, 16'h00FF);
    u_host.send(6, 16'h0038);
    u_host.send(7, 16'hFFFF);
    @(posedge clock_i);
    reset_i <= 1'b0;
    // event bits and masks are unknown after power-up: set them first
    fire(5'h00, 5'h00, 1'b0, 0, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 8, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 5, 16'h00FF, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 6, 16'h0038, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 7, 16'hFFFF, 1'b0);
    live = 1'b1;
    for (int i = 0; i < 5; i++) fire(5'h01 << i, 5'h00, 1'b0, 9, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 3, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 1, 16'h0000, 1'b0);
    fire(5'h08, 5'h00, 1'b0, 1, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 5, 16'h0001, 1'b0);
    do_reset();
    fire(5'h00, 5'h00, 1'b0, 9, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b1, 9, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 8, 16'h0001, 1'b0);
    fire(5'h00, 5'h00, 1'b1, 9, 16'h0000, 1'b0);
    for (int i = 5; i < 8; i++) fire(5'h00, 5'h00, 1'b0, i, 16'hFFFF, 1'b0);
    for (int i = 5; i < 8; i++) fire(5'h00, 5'h00, 1'b0, i, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 7, 16'hFFFF, 1'b0);
    for (int i = 0; i < 5; i++) fire(5'h00, 5'h01 << i, 1'b0, 9, 16'h0000, 1'b0);
    fire(5'h00, 5'h00, 1'b0, 2, 16'h0000, 1'b1);
    fire(5'h00, 5'h00, 1'b0, 9, 16'h0000, 1'b0);
    for (int i = 0; i < 400; i++) begin
      k = $urandom_range(9, 0);
      e = (k == 4) ? 5'h00 : 5'($urandom);
      fire(e, 5'($urandom), (k != 8) && ($urandom_range(15, 0) == 0), k, 16'($urandom),
           1'($urandom) && (k != 0));
    end
    conclude();
  end
endmodule : instrument_status_reporting_tb
